// ### bench/fault_latch_and_alert_clearing_tb.sv
// Bench for the fault latch block: every fault type, clearing reads, re-arm.
// Host model drives the link; faults and reset driven at falling clk.
`timescale 1ns/1ns
module fault_latch_and_alert_clearing_tb;
    import flc_pkg::*;
    localparam longint QUAL = 20;
    logic        clk;
    logic        nrst;
    logic        cs_n;
    logic        sclk;
    logic        mosi;
    logic        miso;
    logic        miso_oe;
    logic [3:0]  raw;
    logic        alert_n_out;
    logic        alert_n_oe;
    logic [3:0]  fault_active;
    logic [1:0]  read_count;
    logic [15:0] f;
    logic [15:0] fi;
    int          failures;
    int          cmp_count;
    int          cycles;
    int          seed;
    flc_fault_latch #(.QUAL(QUAL)) i_dut (
        .clk(clk), .nrst(nrst), .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
        .short_raw(raw[3]), .open_raw(raw[2]), .overtemp_raw(raw[1]), .brownout_raw(raw[0]),
        .alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe),
        .fault_active(fault_active), .read_count(read_count)
    );
    flc_host i_host (
        .clk(clk), .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso), .miso_oe(miso_oe)
    );
    initial clk = 1'b0;
    always #4 clk = ~clk;
    function automatic logic [15:0] err_word(int idx, logic interm);
        err_word = 16'h0000;
        err_word[BIT_BROWN + idx] = 1'b1;
        err_word[BIT_INTERM] = interm;
    endfunction
    task automatic check(string name, logic [15:0] exp, logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic rd(logic [15:0] exp);
        logic [15:0] cmd;
        logic [15:0] rx;
        cmd = 16'($random(seed));
        cmd[CMD_HI:CMD_LO] = CMD_READ_ERR;
        i_host.xfer(cmd, rx);
        check("error word", exp, rx);
    endtask
    task automatic nop(logic [15:0] exp);
        logic [15:0] cmd;
        logic [15:0] rx;
        cmd = 16'($random(seed));
        if (cmd[CMD_HI:CMD_LO] == CMD_READ_ERR) cmd[CMD_LO] = 1'b1;
        i_host.xfer(cmd, rx);
        check("other command word", exp, rx);
    endtask
    task automatic alert_is(logic exp);
        check("alert", {15'h0, exp}, {15'h0, alert_n_oe});
    endtask
    task automatic wait_qual();
        repeat (int'(QUAL) + 6 + ($random(seed) & 7)) @(negedge clk);
    endtask
    task automatic wrap_up();
        if (failures == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            failures++;
            wrap_up();
        end
    end
    initial begin
        seed = 32'h6eb0ed0d;
        nrst = 1'b0;
        raw = 4'h0;
        failures = 0;
        cmp_count = 0;
        cycles = 0;
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        repeat (4) @(negedge clk);
        for (int i = 0; i < N_FAULTS; i++) begin
            f = err_word(i, 1'b0);
            fi = err_word(i, OUTPUT_FAULT_MASK[i]);
            raw[i] = 1'b1;
            wait_qual();
            alert_is(1'b1);
            check("active", 16'h1 << i, {12'h0, fault_active});
            nop(16'h0000);
            alert_is(1'b1);
            rd(16'h0000);
            alert_is(1'b0);
            check("reads", 16'h0001, {14'h0, read_count});
            raw[i] = 1'b0;
            rd(f);
            rd(fi);
            check("reads", 16'h0002, {14'h0, read_count});
            rd(16'h0000);
            raw[i] = 1'b1;
            wait_qual();
            alert_is(1'b1);
            raw[i] = 1'b0;
            repeat (4) @(negedge clk);
            rd(16'h0000);
            rd(fi);
            rd(fi);
            rd(16'h0000);
        end
        f = err_word(1, 1'b0);
        raw[1] = 1'b1;
        wait_qual();
        rd(16'h0000);
        rd(f);
        rd(f);
        rd(f);
        alert_is(1'b0);
        raw[0] = 1'b1;
        repeat (8) @(negedge clk);
        alert_is(1'b1);
        wrap_up();
    end
endmodule

// ### bench/flc_fault_latch_properties.sv
// Checker for the fault latch block: alert, latch and frame timing.
// Sees only the block's ports; bound at the foot of this file.
`timescale 1ns/1ns
module flc_fault_latch_chk
    import flc_pkg::*;
#(
    parameter longint QUAL = QUAL_CYCLES
) (
    // Clock and reset
    input wire logic       clk,
    input wire logic       nrst,
    // Link and faults
    input wire logic       cs_n,
    input wire logic       miso_oe,
    input wire logic       short_raw,
    input wire logic       overtemp_raw,
    input wire logic       brownout_raw,
    // Alert and status
    input wire logic       alert_n_out,
    input wire logic       alert_n_oe,
    input wire logic [3:0] fault_active,
    input wire logic [1:0] read_count
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Clocks the raw short has stayed high
    logic [31:0] run_reg;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) run_reg <= 32'h0;
        else run_reg <= short_raw ? run_reg + 32'h1 : 32'h0;
    end
    sequence s_temp_new;
        $rose(overtemp_raw) && !fault_active[1];
    endsequence
    sequence s_brown_new;
        $rose(brownout_raw) && !fault_active[0];
    endsequence
    a_pull_low: assert property (alert_n_oe |-> !alert_n_out)
        else $error("alert pin not pulled low");
    a_brown_alert: assert property (s_brown_new |-> ##[1:6] alert_n_oe)
        else $error("no alert on new brownout");
    a_temp_alert: assert property (s_temp_new |-> ##[1:6] alert_n_oe)
        else $error("no alert on new overtemp");
    a_drop_read: assert property ($fell(alert_n_oe) |-> read_count == 2'h1)
        else $error("alert dropped without first read");
    a_rise_fresh: assert property ($rose(alert_n_oe) |-> read_count == 2'h0)
        else $error("alert rose with stale read count");
    a_brown_held: assert property (brownout_raw [*5] |-> fault_active[0])
        else $error("present brownout not reported");
    a_short_qual: assert property ($rose(fault_active[3]) |-> $past(run_reg) >= QUAL)
        else $error("short latched before qualification");
    a_idle_oe: assert property (cs_n [*4] |-> !miso_oe)
        else $error("miso driven outside frame");
endmodule

bind flc_fault_latch flc_fault_latch_chk #(.QUAL(QUAL)) u_chk (
    .clk(clk), .nrst(nrst), .cs_n(cs_n), .miso_oe(miso_oe),
    .short_raw(short_raw), .overtemp_raw(overtemp_raw), .brownout_raw(brownout_raw),
    .alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe),
    .fault_active(fault_active), .read_count(read_count)
);

// ### bench/flc_host.sv
// Host model: serial master, mode 0, 16-bit frames, 160 ns sclk.
// Caller enters xfer just after a falling clk edge.
`timescale 1ns/1ns
module flc_host (
    // Clock
    input wire logic clk,
    // Serial link
    output logic     cs_n,
    output logic     sclk,
    output logic     mosi,
    input wire logic miso,
    input wire logic miso_oe
);
    logic last;
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        mosi = 1'b0;
        last = 1'b0;
    end
    // Undriven miso reads as the inverse of its last bit
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        cs_n = 1'b0;
        repeat (10) @(negedge clk);
        for (int k = 15; k >= 0; k--) begin
            mosi = tx[k];
            repeat (10) @(negedge clk);
            sclk = 1'b1;
            rx[k] = miso_oe ? miso : ~last;
            last = rx[k];
            repeat (10) @(negedge clk);
            sclk = 1'b0;
        end
        repeat (10) @(negedge clk);
        cs_n = 1'b1;
        mosi = ~mosi;
        repeat (10) @(negedge clk);
    endtask
endmodule

// ### hdl/flc_fault_latch.sv
// Fault latching, alert pin and serial readback of the error word.
// Assumes a serial host: chip select low frames a 16-bit word, mode 0
// (sample on rising sclk, shift on falling), sclk idle low, all pins asynchronous.
// Output faults pass a persistence filter before they can latch.
`timescale 1ns/1ns

module flc_fault_latch
    import flc_pkg::*;
#(
    parameter longint QUAL = QUAL_CYCLES
) (
    // Clock and reset
    clk,
    nrst,
    // Serial link pins
    cs_n,
    sclk,
    mosi,
    miso,
    miso_oe,
    // Raw fault conditions
    short_raw,
    open_raw,
    overtemp_raw,
    brownout_raw,
    // Alert pin, open drain: pulls low while alerting
    alert_n_out,
    alert_n_oe,
    // Status
    fault_active,
    read_count
);
    // Clock and reset
    input  wire logic       clk;
    input  wire logic       nrst;

    // Serial link pins
    input  wire logic       cs_n;
    input  wire logic       sclk;
    input  wire logic       mosi;
    output logic            miso;
    output logic            miso_oe;

    // Raw fault conditions
    input  wire logic       short_raw;
    input  wire logic       open_raw;
    input  wire logic       overtemp_raw;
    input  wire logic       brownout_raw;

    // Alert pin
    output logic            alert_n_out;
    output logic            alert_n_oe;

    // Status
    output logic [3:0]      fault_active;
    output logic [1:0]      read_count;

    typedef struct packed {
        flc_frame_st_t          fst;
        logic                   sclk_d;
        logic [FRAME_BITS-1:0]  rx;
        logic [FRAME_BITS-1:0]  tx;
        logic [FRAME_BITS-1:0]  resp;      // Word for the next frame
        logic                   link_ok;   // Deselect seen since reset
        logic [4:0]             nbits;
        logic [N_FAULTS-1:0]    latched;   // Faults in the error word
        logic [N_FAULTS-1:0]    reported;  // Faults already alerted
        logic [N_FAULTS-1:0]    interm;    // Output faults that went away
        logic [N_FAULTS-1:0]    prev;      // Conditions at last clock
        logic [1:0]             reads;
        logic                   alert;
        logic                   miso_q;
        logic                   miso_oe_q;
        logic [N_FAULTS-1:0]    act_q;
    } flc_st_t;

    flc_st_t st_reg;
    flc_st_t st_next;

    logic [2:0]          pins_s;
    logic [N_FAULTS-1:0] raw_s;
    logic [N_FAULTS-1:0] cond;
    logic                cs_n_s;
    logic                sclk_s;
    logic                mosi_s;

    // Link pins and fault levels cross into clk through two flops
    flc_sync #(.WIDTH(3)) u_sync_pins (
        .clk  (clk),
        .nrst (nrst),
        .din  ({cs_n, sclk, mosi}),
        .dout (pins_s)
    );

    flc_sync #(.WIDTH(N_FAULTS)) u_sync_faults (
        .clk  (clk),
        .nrst (nrst),
        .din  ({short_raw, open_raw, overtemp_raw, brownout_raw}),
        .dout (raw_s)
    );

    assign cs_n_s = pins_s[2];
    assign sclk_s = pins_s[1];
    assign mosi_s = pins_s[0];

    // Output faults need persistence; overtemp and brownout pass directly
    genvar gi;
    generate
        for (gi = 0; gi < N_FAULTS; gi++) begin : g_qual
            if (OUTPUT_FAULT_MASK[gi]) begin : g_out
                flc_qual #(.CYCLES(QUAL)) u_qual (
                    .clk       (clk),
                    .nrst      (nrst),
                    .raw       (raw_s[gi]),
                    .qualified (cond[gi])
                );
            end else begin : g_dir
                assign cond[gi] = raw_s[gi];
            end
        end
    endgenerate

    logic                  rise;
    logic                  fall;
    logic                  frame_end;
    logic                  is_err_read;
    logic [FRAME_BITS-1:0] word;
    logic [N_FAULTS-1:0]   new_fault;
    logic [N_FAULTS-1:0]   gone;
    logic [2:0]            cmd_field;

    assign rise = sclk_s && !st_reg.sclk_d;
    assign fall = !sclk_s && st_reg.sclk_d;

    always_comb begin
        st_next     = st_reg;
        frame_end   = 1'b0;
        is_err_read = 1'b0;
        word        = DOUT_RESET;
        cmd_field   = st_reg.rx[CMD_HI:CMD_LO];
        st_next.sclk_d = sclk_s;
        // Select syncs reset low; wait for a deselect before framing
        st_next.link_ok = st_reg.link_ok | cs_n_s;
        // Latched output faults whose condition just went away
        gone = st_reg.latched & st_reg.prev & ~cond & OUTPUT_FAULT_MASK;

        // Error word built from the latch state and present conditions
        word[BIT_SHORT] = st_reg.latched[3] | cond[3];
        word[BIT_OPEN]  = st_reg.latched[2] | cond[2];
        word[BIT_OVERT] = st_reg.latched[1] | cond[1];
        word[BIT_BROWN] = st_reg.latched[0] | cond[0];
        word[BIT_INTERM] = |((st_reg.interm | gone) & OUTPUT_FAULT_MASK);

        // Frame shifting
        case (st_reg.fst)
            FLC_IDLE: begin
                st_next.miso_oe_q = 1'b0;
                if (!cs_n_s && st_reg.link_ok) begin
                    st_next.fst       = FLC_SHIFT;
                    st_next.nbits     = '0;
                    st_next.rx        = '0;
                    st_next.tx        = st_reg.resp;
                    st_next.miso_q    = st_reg.resp[FRAME_BITS-1];
                    st_next.miso_oe_q = 1'b1;
                end
            end
            FLC_SHIFT: begin
                // Cut frame: back to idle without a step
                if (cs_n_s) begin
                    st_next.fst       = FLC_IDLE;
                    st_next.miso_oe_q = 1'b0;
                end else begin
                    // Host data taken on the rising edge
                    if (rise) begin
                        st_next.rx    = {st_reg.rx[FRAME_BITS-2:0], mosi_s};
                        st_next.nbits = st_reg.nbits + 5'h1;
                    end
                    // Next bit shown after the falling edge
                    if (fall) begin
                        st_next.tx     = {st_reg.tx[FRAME_BITS-2:0], 1'b0};
                        st_next.miso_q = st_reg.tx[FRAME_BITS-2];
                    end
                    // Rises after the last bit are ignored
                    if (st_reg.nbits == 5'(FRAME_BITS)) begin
                        st_next.fst = FLC_DONE;
                    end
                end
            end
            // Only a full frame closed by deselect steps the logic
            FLC_DONE: begin
                if (cs_n_s) begin
                    st_next.fst       = FLC_IDLE;
                    st_next.miso_oe_q = 1'b0;
                    frame_end         = 1'b1;
                end
            end
            default: begin
                st_next.fst = FLC_IDLE;
            end
        endcase

        // Alert on a fault not yet reported; set wins over a clearing read
        new_fault = cond & ~st_reg.reported;
        if (|new_fault) begin
            st_next.alert    = 1'b1;
            st_next.reported = st_reg.reported | new_fault;
            st_next.latched  = st_next.latched | new_fault;
            st_next.reads    = '0;
        end

        // Output faults that disappear while latched are intermittent
        st_next.interm = st_next.interm | gone;
        st_next.prev = cond;

        // Read frame steps the reporting logic
        if (frame_end) begin
            is_err_read = (cmd_field == CMD_READ_ERR);
            if (is_err_read) begin
                st_next.resp = word; // Next frame returns this word
                if (st_reg.reads == 2'h0) begin
                    // A fault arriving with the read keeps the alert up
                    if (!(|new_fault)) begin
                        st_next.alert = 1'b0;
                        st_next.reads = 2'h1;
                    end
                end else begin
                    // Clear latch; still-present faults stay reported
                    st_next.latched  = new_fault;
                    st_next.interm   = '0;
                    st_next.reported = cond | new_fault;
                    if (!(|new_fault)) begin
                        st_next.reads = 2'h2;
                    end
                end
            end else begin
                // Other commands return zero in the next frame
                st_next.resp = DOUT_RESET;
            end
        end
        // Status shows latched or still present faults
        st_next.act_q = st_next.latched | cond;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_reg.fst       <= FLC_IDLE;
            st_reg.sclk_d    <= 1'b0;
            st_reg.rx        <= '0;
            st_reg.tx        <= '0;
            st_reg.resp      <= DOUT_RESET;
            st_reg.link_ok   <= 1'b0;
            st_reg.nbits     <= '0;
            st_reg.latched   <= '0;
            st_reg.reported  <= '0;
            st_reg.interm    <= '0;
            st_reg.prev      <= '0;
            st_reg.reads     <= '0;
            st_reg.alert     <= 1'b0;
            st_reg.miso_q    <= 1'b0;
            st_reg.miso_oe_q <= 1'b0;
            st_reg.act_q     <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign miso         = st_reg.miso_q;
    assign miso_oe      = st_reg.miso_oe_q;
    // Open drain: pull value fixed low, enable carries the alert
    assign alert_n_out  = 1'b0;
    assign alert_n_oe   = st_reg.alert;
    assign fault_active = st_reg.act_q;
    assign read_count   = st_reg.reads;
endmodule

// ### hdl/flc_pkg.sv
// Package for the fault latch and alert block.
// Assumes a 16-bit serial frame, MSB first, command address in bits 13:11.
package flc_pkg;
    localparam int FRAME_BITS  = 16;
    localparam int CMD_HI      = 13;
    localparam int CMD_LO      = 11;
    localparam logic [2:0] CMD_READ_ERR = 3'h4;
    localparam int BIT_INTERM  = 9;
    localparam int BIT_SHORT   = 8;
    localparam int BIT_OPEN    = 7;
    localparam int BIT_OVERT   = 6;
    localparam int BIT_BROWN   = 5;
    localparam int N_FAULTS    = 4;
    // Fault index order: 3 short, 2 open, 1 overtemp, 0 brownout
    localparam logic [3:0] OUTPUT_FAULT_MASK = 4'hc;
    localparam logic [15:0] DOUT_RESET = 16'h0000;
    // Qualification time for output faults
    localparam int QUAL_MS      = 260;
    localparam int CLK_MHZ      = 125;
    localparam longint QUAL_CYCLES = longint'(QUAL_MS) * 1000 * 1000 * CLK_MHZ / 1000;

    typedef enum logic [2:0] {
        FLC_IDLE  = 3'b001,
        FLC_SHIFT = 3'b010,
        FLC_DONE  = 3'b100
    } flc_frame_st_t;
endpackage

// ### hdl/flc_qual.sv
// Persistence filter: output asserts after the input stays high for CYCLES+1 clocks.
// Assumes a synchronised input; input low clears the count at once.
`timescale 1ns/1ns
module flc_qual
    import flc_pkg::*;
#(
    parameter longint CYCLES = QUAL_CYCLES
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // Condition
    input  wire logic raw,
    output logic      qualified
);
    typedef struct packed {
        logic [31:0] cnt;
        logic        q;
    } flc_qual_st_t;

    localparam logic [31:0] LIMIT = 32'(CYCLES);

    flc_qual_st_t st_reg;
    flc_qual_st_t st_next;

    always_comb begin
        st_next = st_reg;
        if (!raw) begin
            st_next.cnt = '0;
            st_next.q   = 1'b0;
        end else if (st_reg.cnt < LIMIT) begin
            st_next.cnt = st_reg.cnt + 32'h1;
        end else begin
            st_next.q = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign qualified = st_reg.q;
endmodule

// ### hdl/flc_sync.sv
// Two-flip-flop synchroniser, one per bit.
// Assumes asynchronous inputs and an active-low asynchronous reset.
`timescale 1ns/1ns
module flc_sync
    import flc_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    // Data
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } flc_sync_st_t;

    flc_sync_st_t st_reg;
    flc_sync_st_t st_next;

    always_comb begin
        st_next    = st_reg;
        st_next.s1 = din;
        st_next.s2 = st_reg.s1;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign dout = st_reg.s2;
endmodule
